// [hdl/htu_device.sv]
`timescale 1ns/1ps
// Summary of operation
// - One UART carries commands, events, data.
// - Four-wire hardware or three-wire software flow.
// - First received byte selects the transport.
// - Start at 115.2 kbps, up to 4 Mbps.
// - Answer at old rate, then switch rate.
// - Eight data bits, one stop, optional even parity.
// - Flag break, idle, framing, overflow, parity, underflow.
// - Outside three-wire, raise flow output when buffer reaches threshold.
// - Outside three-wire, flow input high stops transmit after byte.
// - Sleep transitions signalled on flow lines.
// - Three-wire side pauses with XON and XOFF.
// - Shutdown leaves every pin high impedance.
// - Active and sleep drive transmit, flow; sleep drives both high.
// - Slow clock stable 2 ms after shutdown.
// - Flow output low within 100 ms.
module htu_device
  import htu_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int DEPTH = RXBUF_DEPTH,
  parameter int THRESH = RXBUF_THRESH
) (
  input wire logic clk,
  input wire logic rst,
  htu_link_if.device link,
  input wire logic parity_en,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_frame,
  input wire logic set_rate,
  input wire logic [DIV_W-1:0] new_div,
  input wire logic sleep_req,
  output logic awake,
  output logic wake,
  output logic mode_known,
  output logic mode_three,
  output logic frame_err,
  output logic parity_err,
  output logic break_det,
  output logic idle_det,
  output logic overflow,
  output logic underflow,
  output logic audio_serial_out_oe_n
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);
  logic [1:0] s1, s2, s3, pin_q;
  logic rxd, cts;
  logic cts_d;
  htu_mode_e mode;
  htu_pwr_e pwr;
  logic [31:0] pu_cnt;
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr, rd;
  logic [CW-1:0] count;
  logic push, pop, flow_byte;
  logic [DIV_W-1:0] div, pend_div;
  logic rate_pending;
  logic peer_paused, xoff_sent, flow_pend;
  logic [7:0] flow_char;
  logic start, allowed, busy, busy_q;
  logic [7:0] start_data;
  logic [7:0] eng_data;
  logic eng_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Three stages; a pin change is taken once stages two and three agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      pin_q <= 2'h3;
    end else begin
      s1 <= {link.host_link_flow_in, link.host_link_receive};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == s3[i]) begin
          pin_q[i] <= s3[i];
        end
      end
    end
  end
  assign rxd = pin_q[0];
  assign cts = pin_q[1];

  htu_serial u_serial (
    .clk(clk),
    .rst(rst),
    .div(div),
    .parity_en(parity_en),
    .tx_data(start_data),
    .tx_start(start),
    .tx_busy(busy),
    .txd(link.host_link_transmit),
    .rxd(rxd),
    .rx_data(eng_data),
    .rx_valid(eng_valid),
    .frame_err(frame_err),
    .parity_err(parity_err),
    .break_det(break_det),
    .idle_det(idle_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The first byte decides: a frame delimiter means three-wire.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= HTU_MODE_UNKNOWN;
    end else if (mode == HTU_MODE_UNKNOWN && eng_valid) begin
      mode <= (eng_data == CHAR_SLIP) ? HTU_MODE_THREE : HTU_MODE_FOUR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer with a registered head for the user side.
  assign flow_byte = (mode == HTU_MODE_THREE) &&
                     (eng_data == CHAR_XON || eng_data == CHAR_XOFF);
  assign push = eng_valid && !flow_byte && (count != CW'(DEPTH));
  assign pop = (count != '0) && (!rx_valid || rx_ready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr <= '0;
      rd <= '0;
      count <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= eng_valid && !flow_byte && (count == CW'(DEPTH));
      if (push) begin
        mem[wr] <= eng_data;
        wr <= (wr == AW'(DEPTH - 1)) ? '0 : wr + 1'b1;
      end
      if (pop) begin
        rx_data <= mem[rd];
        rd <= (rd == AW'(DEPTH - 1)) ? '0 : rd + 1'b1;
      end
      if (pop || (rx_valid && rx_ready)) begin
        rx_valid <= pop;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencing and the sleep handshake.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr <= HTU_PWR_START;
      pu_cnt <= '0;
      cts_d <= 1'b1;
      wake <= 1'b0;
    end else begin
      cts_d <= cts;
      wake <= 1'b0;
      unique case (pwr)
        HTU_PWR_START: begin
          pu_cnt <= pu_cnt + 1'b1;
          if (pu_cnt == 32'(POWERUP_CYCLES - 1)) begin
            pwr <= HTU_PWR_ACTIVE;
          end
        end
        HTU_PWR_ACTIVE: begin
          if (sleep_req && !busy && !tx_valid && !start) begin
            pwr <= HTU_PWR_SLEEP;
          end
        end
        HTU_PWR_SLEEP: begin
          // The host raising its flow line is the wake request.
          if (!sleep_req || (cts && !cts_d)) begin
            pwr <= HTU_PWR_ACTIVE;
            wake <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software flow: track the peer's XOFF and send our own at threshold.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peer_paused <= 1'b0;
      xoff_sent <= 1'b0;
      flow_pend <= 1'b0;
      flow_char <= CHAR_XON;
    end else begin
      if (eng_valid && flow_byte) begin
        peer_paused <= (eng_data == CHAR_XOFF);
      end
      if (start && flow_pend) begin
        flow_pend <= 1'b0;
      end else if (mode == HTU_MODE_THREE && !flow_pend) begin
        if (!xoff_sent && count >= CW'(THRESH)) begin
          flow_pend <= 1'b1;
          flow_char <= CHAR_XOFF;
          xoff_sent <= 1'b1;
        end else if (xoff_sent && count < CW'(THRESH)) begin
          flow_pend <= 1'b1;
          flow_char <= CHAR_XON;
          xoff_sent <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit gating. The engine finishes any byte in flight before a stop.
  assign allowed = (pwr == HTU_PWR_ACTIVE) && !rate_pending &&
                   ((mode == HTU_MODE_THREE) ? !peer_paused : !cts);
  assign start = !busy && !busy_q && (flow_pend ? (pwr == HTU_PWR_ACTIVE) : (tx_ready && tx_valid));
  assign start_data = flow_pend ? flow_char : tx_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      busy_q <= 1'b0;
      underflow <= 1'b0;
    end else begin
      busy_q <= busy;
      tx_ready <= !start && !busy && allowed && !flow_pend;
      underflow <= busy_q && !busy && tx_frame && !tx_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A rate change waits for the last byte at the old rate to leave.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= DIV_DEFAULT;
      pend_div <= DIV_DEFAULT;
      rate_pending <= 1'b0;
    end else if (set_rate) begin
      rate_pending <= 1'b1;
      pend_div <= (new_div < DIV_MIN) ? DIV_MIN : new_div;
    end else if (rate_pending && !busy && !busy_q && !start) begin
      div <= pend_div;
      rate_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins float during shutdown; transmit and flow are driven from the first edge after it, the audio pin stays floating.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.host_link_transmit_oe_n <= 1'b1;
      link.host_link_flow_out_oe_n <= 1'b1;
      link.host_link_flow_out <= 1'b1;
      audio_serial_out_oe_n <= 1'b1;
      awake <= 1'b0;
      mode_known <= 1'b0;
      mode_three <= 1'b0;
    end else begin
      link.host_link_transmit_oe_n <= 1'b0;
      link.host_link_flow_out_oe_n <= 1'b0;
      audio_serial_out_oe_n <= 1'b1;
      link.host_link_flow_out <= (pwr != HTU_PWR_ACTIVE) ||
                                 (mode != HTU_MODE_THREE && count >= CW'(THRESH));
      awake <= (pwr == HTU_PWR_ACTIVE);
      mode_known <= (mode != HTU_MODE_UNKNOWN);
      mode_three <= (mode == HTU_MODE_THREE);
    end
  end
endmodule

// [hdl/htu_pkg.sv]
package htu_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MAX = 4_000_000;
  localparam int DIV_W = 12;
  localparam logic [11:0] DIV_DEFAULT = 12'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [11:0] DIV_MIN = 12'(CLK_HZ / BAUD_MAX);
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int IDLE_BITS = 10;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_SLIP = 8'hc0;
  localparam int POWERUP_MS = 100;
  localparam int POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
  localparam int SLOW_STABLE_CYCLES = 64;
  localparam int SLOW_STABLE_MS = 2;
  localparam int RXBUF_DEPTH = 8;
  localparam int RXBUF_THRESH = 6;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    HTU_MODE_UNKNOWN = 3'b001,
    HTU_MODE_FOUR = 3'b010,
    HTU_MODE_THREE = 3'b100
  } htu_mode_e;

  typedef enum logic [2:0] {
    HTU_PWR_START = 3'b001,
    HTU_PWR_ACTIVE = 3'b010,
    HTU_PWR_SLEEP = 3'b100
  } htu_pwr_e;
endpackage

// [hdl/htu_link_if.sv]
`timescale 1ns/1ps
interface htu_link_if;
  logic host_link_transmit;
  logic host_link_transmit_oe_n;
  logic host_link_flow_out;
  logic host_link_flow_out_oe_n;
  logic host_link_receive;
  logic host_link_flow_in;
  logic tx_line;
  logic rts_line;

  // Undriven device pins float to the pullup level.
  assign tx_line = host_link_transmit_oe_n ? 1'b1 : host_link_transmit;
  assign rts_line = host_link_flow_out_oe_n ? 1'b1 : host_link_flow_out;

  modport device (
    output host_link_transmit,
    output host_link_transmit_oe_n,
    output host_link_flow_out,
    output host_link_flow_out_oe_n,
    input host_link_receive,
    input host_link_flow_in
  );

  modport host (
    input tx_line,
    input rts_line,
    output host_link_receive,
    output host_link_flow_in
  );
endinterface

// [hdl/htu_serial.sv]
`timescale 1ns/1ps
module htu_serial
  import htu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DIV_W-1:0] div,
  input wire logic parity_en,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy,
  output logic txd,
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic frame_err,
  output logic parity_err,
  output logic break_det,
  output logic idle_det
);
  logic [9:0] tx_sh;
  logic [3:0] tx_left;
  logic [DIV_W-1:0] tx_tick;
  logic rx_busy;
  logic [3:0] rx_idx;
  logic [DIV_W-1:0] rx_tick;
  logic [7:0] rx_sh;
  logic rx_par;
  logic idle_arm;
  logic [15:0] idle_cnt;
  logic [3:0] last_idx;

  assign last_idx = parity_en ? 4'ha : 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Start low, data LSB first, optional even parity, stop high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      tx_sh <= '0;
      tx_left <= '0;
      tx_tick <= '0;
    end else if (!tx_busy) begin
      if (tx_start) begin
        txd <= 1'b0;
        tx_sh <= {1'b1, parity_en ? ^tx_data : 1'b1, tx_data};
        tx_left <= parity_en ? 4'ha : 4'h9;
        tx_busy <= 1'b1;
        tx_tick <= div - 1'b1;
      end
    end else if (tx_tick != '0) begin
      tx_tick <= tx_tick - 1'b1;
    end else begin
      tx_tick <= div - 1'b1;
      if (tx_left == '0) begin
        tx_busy <= 1'b0;
      end else begin
        txd <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_left <= tx_left - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_idx <= '0;
      rx_tick <= '0;
      rx_sh <= '0;
      rx_par <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
      break_det <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
      break_det <= 1'b0;
      if (!rx_busy) begin
        if (!rxd) begin
          rx_busy <= 1'b1;
          rx_idx <= '0;
          rx_tick <= div >> 1;
        end
      end else if (rx_tick != '0) begin
        rx_tick <= rx_tick - 1'b1;
      end else begin
        rx_tick <= div - 1'b1;
        rx_idx <= rx_idx + 1'b1;
        if (rx_idx == '0) begin
          rx_busy <= !rxd;
        end else if (rx_idx <= 4'h8) begin
          rx_sh <= {rxd, rx_sh[7:1]};
        end else if (rx_idx < last_idx) begin
          rx_par <= rxd;
        end else begin
          // A low stop level after all-zero data is a break, not a character.
          rx_busy <= 1'b0;
          rx_data <= rx_sh;
          frame_err <= !rxd;
          break_det <= !rxd && (rx_sh == '0) && (!parity_en || !rx_par);
          rx_valid <= rxd;
          parity_err <= rxd && parity_en && (rx_par != ^rx_sh);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_arm <= 1'b0;
      idle_cnt <= '0;
      idle_det <= 1'b0;
    end else begin
      idle_det <= 1'b0;
      if (rx_valid || frame_err) begin
        idle_arm <= 1'b1;
        idle_cnt <= '0;
      end else if (idle_arm && !rx_busy && rxd) begin
        idle_cnt <= idle_cnt + 1'b1;
        if (idle_cnt == 16'(div * IDLE_BITS)) begin
          idle_det <= 1'b1;
          idle_arm <= 1'b0;
        end
      end else if (rx_busy) begin
        idle_arm <= 1'b0;
      end
    end
  end
endmodule

// [hdl/htu_host.sv]
`timescale 1ns/1ps
module htu_host
  import htu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  htu_link_if.host link,
  input wire logic three_wire,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic hold,
  input wire logic set_rate,
  input wire logic [DIV_W-1:0] new_div,
  output logic device_ready
);
  logic [1:0] s1, s2, s3, pin_q;
  logic [DIV_W-1:0] div;
  logic busy, busy_q, start, paused, xoff_sent, flow_pend;
  logic [7:0] flow_char, eng_data;
  logic eng_valid, flow_byte;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      pin_q <= 2'h3;
    end else begin
      s1 <= {link.rts_line, link.tx_line};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == s3[i]) begin
          pin_q[i] <= s3[i];
        end
      end
    end
  end

  htu_serial u_serial (
    .clk(clk),
    .rst(rst),
    .div(div),
    .parity_en(1'b0),
    .tx_data(flow_pend ? flow_char : tx_data),
    .tx_start(start),
    .tx_busy(busy),
    .txd(link.host_link_receive),
    .rxd(pin_q[0]),
    .rx_data(eng_data),
    .rx_valid(eng_valid),
    .frame_err(),
    .parity_err(),
    .break_det(),
    .idle_det()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Device flow line low means it may receive; XON/XOFF are consumed here.
  assign flow_byte = three_wire && (eng_data == CHAR_XON || eng_data == CHAR_XOFF);
  assign start = !busy && !busy_q && (flow_pend || (tx_ready && tx_valid));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      paused <= 1'b0;
      xoff_sent <= 1'b0;
      flow_pend <= 1'b0;
      flow_char <= CHAR_XON;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= '0;
      device_ready <= 1'b0;
      link.host_link_flow_in <= 1'b0;
    end else begin
      busy_q <= busy;
      rx_valid <= eng_valid && !flow_byte;
      rx_data <= eng_data;
      if (eng_valid && flow_byte) begin
        paused <= (eng_data == CHAR_XOFF);
      end
      if (start && flow_pend) begin
        flow_pend <= 1'b0;
      end else if (three_wire && !flow_pend && (hold != xoff_sent)) begin
        flow_pend <= 1'b1;
        flow_char <= hold ? CHAR_XOFF : CHAR_XON;
        xoff_sent <= hold;
      end
      tx_ready <= !start && !busy && !flow_pend &&
                  (three_wire ? !paused : !pin_q[1]);
      device_ready <= !pin_q[1];
      // Raising the flow line also serves as the wake request.
      link.host_link_flow_in <= hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The user changes rate only after the device's completion event.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= DIV_DEFAULT;
    end else if (set_rate) begin
      div <= (new_div < DIV_MIN) ? DIV_MIN : new_div;
    end
  end
endmodule

// [bench/htu_link_properties.sv]
`timescale 1ns/1ps
module htu_link_properties #(
  parameter int POWERUP_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_link_transmit_oe_n,
  input wire logic host_link_flow_out_oe_n,
  input wire logic host_link_receive,
  input wire logic host_link_flow_in,
  input wire logic tx_line,
  input wire logic rts_line
);
  // One default-rate character plus sync lag; a start bit after this long a stall is a breach.
  localparam int STALL = 4000;
  int up_cnt;
  int cts_cnt;
  int rts_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 0;
    end else if (up_cnt < POWERUP_CYCLES + 8) begin
      up_cnt <= up_cnt + 1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cts_cnt <= 0;
    end else begin
      cts_cnt <= host_link_flow_in ? cts_cnt + 1 : 0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_cnt <= 0;
    end else begin
      rts_cnt <= rts_line ? rts_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_shutdown_hi_z:
  assert property (@(posedge clk) rst |-> host_link_transmit_oe_n && host_link_flow_out_oe_n)
    else $error("device pins driven during shutdown");
  a_active_pins_driven:
  assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> !host_link_transmit_oe_n && !host_link_flow_out_oe_n)
    else $error("device pins not driven while active");
  a_powerup_flow_hold:
  assert property (@(posedge clk) disable iff (rst) up_cnt < POWERUP_CYCLES - 1 |-> rts_line)
    else $error("flow output low before power-up done");
  a_powerup_ready_low:
  assert property (@(posedge clk) disable iff (rst) up_cnt == POWERUP_CYCLES + 4 |-> !rts_line)
    else $error("flow output not low after power-up");
  a_tx_start_bit:
  assert property (@(posedge clk) disable iff (rst) $fell(tx_line) |=> !tx_line [*8])
    else $error("device start bit too short");
  a_rx_start_bit:
  assert property (@(posedge clk) disable iff (rst)
    $fell(host_link_receive) |=> !host_link_receive [*8])
    else $error("host start bit too short");
  a_cts_halts_tx:
  assert property (@(posedge clk) disable iff (rst) cts_cnt > STALL |-> !$fell(tx_line))
    else $error("device started a byte while stopped");
  a_rts_halts_host:
  assert property (@(posedge clk) disable iff (rst)
    rts_cnt > STALL |-> !$fell(host_link_receive))
    else $error("host started a byte while stopped");
  c_device_byte: cover property (@(posedge clk) disable iff (rst) $fell(tx_line));
  c_host_byte: cover property (@(posedge clk) disable iff (rst) $fell(host_link_receive));
  c_long_stall: cover property (@(posedge clk) disable iff (rst) cts_cnt == STALL + 1);
endmodule

// [bench/host_transport_uart_tb.sv]
`timescale 1ns/1ps
module host_transport_uart_tb;
  import htu_pkg::*;
  localparam int PU = 50;
  typedef struct packed {
    logic dev;
    logic [7:0] data;
    logic [7:0] exp;
  } htu_row_s;
  htu_row_s rows [4] = '{'{1'b0, 8'h01, 8'h01}, '{1'b1, 8'ha5, 8'ha5}, '{1'b0, 8'hff, 8'hff},
    '{1'b1, 8'h00, 8'h00}};
  logic clk = 1'b0, rst = 1'b0, rx_ready = 1'b0, d_tx_valid = 1'b0, tx_frame = 1'b0;
  logic d_set_rate = 1'b0, sleep_req = 1'b0, three_wire = 1'b0, h_tx_valid = 1'b0;
  logic hold = 1'b0, h_set_rate = 1'b0, seen_uf = 1'b0, seen_idle = 1'b0, seen_wake = 1'b0;
  logic [7:0] d_tx_data = 8'h00, h_tx_data = 8'h00, d_rx_data, h_rx_data;
  logic [DIV_W-1:0] new_div = DIV_DEFAULT;
  logic d_rx_valid, d_tx_ready, awake, wake, mode_known, mode_three, idle_det, underflow;
  logic aud_oe_n, h_tx_ready, h_rx_valid, device_ready;
  logic [7:0] hq [$];
  int err_total = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (h_rx_valid === 1'b1) hq.push_back(h_rx_data);
    if (underflow === 1'b1) seen_uf <= 1'b1;
    if (idle_det === 1'b1) seen_idle <= 1'b1;
    if (wake === 1'b1) seen_wake <= 1'b1;
  end
  htu_link_if link ();
  htu_device #(.POWERUP_CYCLES(PU)) u_htu_device (.clk(clk), .rst(rst), .link(link.device),
    .parity_en(1'b0), .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_ready(rx_ready),
    .tx_data(d_tx_data), .tx_valid(d_tx_valid), .tx_ready(d_tx_ready), .tx_frame(tx_frame),
    .set_rate(d_set_rate), .new_div(new_div), .sleep_req(sleep_req), .awake(awake),
    .wake(wake), .mode_known(mode_known), .mode_three(mode_three), .frame_err(),
    .parity_err(), .break_det(), .idle_det(idle_det), .overflow(), .underflow(underflow),
    .audio_serial_out_oe_n(aud_oe_n));
  htu_host u_htu_host (.clk(clk), .rst(rst), .link(link.host), .three_wire(three_wire),
    .tx_data(h_tx_data), .tx_valid(h_tx_valid), .tx_ready(h_tx_ready), .rx_data(h_rx_data),
    .rx_valid(h_rx_valid), .hold(hold), .set_rate(h_set_rate), .new_div(new_div),
    .device_ready(device_ready));
  htu_link_properties #(.POWERUP_CYCLES(PU)) u_htu_link_properties (.clk(clk), .rst(rst),
    .host_link_transmit_oe_n(link.host_link_transmit_oe_n),
    .host_link_flow_out_oe_n(link.host_link_flow_out_oe_n),
    .host_link_receive(link.host_link_receive), .host_link_flow_in(link.host_link_flow_in),
    .tx_line(link.tx_line), .rts_line(link.rts_line));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic note(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The request stays up until the edge where ready is seen high, then drops.
  task automatic send(input logic dev, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    if (dev) begin
      d_tx_data = b;
      d_tx_valid = 1'b1;
    end else begin
      h_tx_data = b;
      h_tx_valid = 1'b1;
    end
    while ((dev ? d_tx_ready : h_tx_ready) !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #2 n++;
    end
    @(posedge clk);
    #2;
    if (dev) d_tx_valid = 1'b0;
    else h_tx_valid = 1'b0;
  endtask
  task automatic dev_recv(input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    while (d_rx_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #2 n++;
    end
    chk_byte(d_rx_data, exp);
    rx_ready = 1'b1;
    @(posedge clk);
    #2 rx_ready = 1'b0;
  endtask
  task automatic host_recv(input logic [7:0] exp);
    int n;
    n = 0;
    while (hq.size() == 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    #2 chk_byte(hq.size() > 0 ? hq.pop_front() : 8'hxx, exp);
  endtask
  task automatic wire_watch(input logic [7:0] b, input int div);
    @(negedge link.tx_line);
    repeat (div / 2) @(posedge clk);
    #1 chk_bit(link.tx_line, 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      #1 chk_bit(link.tx_line, b[i]);
    end
    repeat (div) @(posedge clk);
    #1 chk_bit(link.tx_line, 1'b1);
  endtask
  task automatic rate(input logic dev);
    @(posedge clk);
    #2;
    if (dev) d_set_rate = 1'b1;
    else h_set_rate = 1'b1;
    @(posedge clk);
    #2 d_set_rate = 1'b0;
    h_set_rate = 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    #2 rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 chk_bit(link.host_link_transmit_oe_n & link.host_link_flow_out_oe_n, 1'b1);
    chk_bit(link.tx_line & link.rts_line, 1'b1);
    rst = 1'b0;
    repeat (PU + 10) @(posedge clk);
    #2 chk_bit(link.rts_line, 1'b0);
    chk_bit(link.tx_line & ~link.host_link_transmit_oe_n & aud_oe_n, 1'b1);
    chk_bit(device_ready & awake, 1'b1);
    note("reset");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    // A real rising edge is needed so that the asynchronous reset fires before the first clock.
    #1 rst = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].dev) begin
        fork
          wire_watch(rows[i].exp, int'(DIV_DEFAULT));
          send(1'b1, rows[i].data);
        join
        host_recv(rows[i].exp);
      end else begin
        send(1'b0, rows[i].data);
        dev_recv(rows[i].exp);
      end
    end
    chk_bit(mode_known & ~mode_three, 1'b1);
    note("rows");
    new_div = 12'h00a;
    fork
      wire_watch(8'h0e, int'(DIV_DEFAULT));
      begin
        send(1'b1, 8'h0e);
        rate(1'b1);
      end
    join
    host_recv(8'h0e);
    rate(1'b0);
    fork
      wire_watch(8'h3c, 10);
      send(1'b1, 8'h3c);
    join
    host_recv(8'h3c);
    send(1'b0, 8'hc3);
    dev_recv(8'hc3);
    note("rate");
    // The buffer head holds one byte outside the count, so one extra byte reaches the threshold.
    for (int i = 0; i <= RXBUF_THRESH; i++) send(1'b0, 8'h40 + 8'(i));
    repeat (150) @(posedge clk);
    #2 chk_bit(link.rts_line, 1'b1);
    fork
      send(1'b0, 8'h40 + 8'(RXBUF_THRESH + 1));
    join_none
    for (int i = 0; i <= RXBUF_THRESH + 1; i++) dev_recv(8'h40 + 8'(i));
    seen_idle = 1'b0;
    repeat (150) @(posedge clk);
    #2 chk_bit(link.rts_line, 1'b0);
    chk_bit(seen_idle, 1'b1);
    note("flow");
    send(1'b1, 8'h78);
    // Raised mid-byte: that byte must still finish, the next must wait.
    hold = 1'b1;
    fork
      send(1'b1, 8'h77);
    join_none
    repeat (4500) @(posedge clk);
    host_recv(8'h78);
    chk_bit(hq.size() == 0, 1'b1);
    hold = 1'b0;
    host_recv(8'h77);
    note("stop");
    tx_frame = 1'b1;
    send(1'b1, 8'h55);
    host_recv(8'h55);
    repeat (20) @(posedge clk);
    #2 tx_frame = 1'b0;
    chk_bit(seen_uf, 1'b1);
    sleep_req = 1'b1;
    repeat (10) @(posedge clk);
    #2 chk_bit(awake | ~link.rts_line, 1'b0);
    sleep_req = 1'b0;
    repeat (10) @(posedge clk);
    #2 chk_bit(awake & ~link.rts_line & seen_wake, 1'b1);
    note("sleep");
    three_wire = 1'b1;
    do_reset();
    send(1'b0, CHAR_SLIP);
    dev_recv(CHAR_SLIP);
    chk_bit(mode_known & mode_three, 1'b1);
    hold = 1'b1;
    repeat (4000) @(posedge clk);
    fork
      send(1'b1, 8'h66);
    join_none
    repeat (4000) @(posedge clk);
    #2 chk_bit(hq.size() == 0, 1'b1);
    hold = 1'b0;
    host_recv(8'h66);
    note("three wire");
    end_of_test();
  end
endmodule
